//--- hdl/peak_oc_pkg.sv
package peak_oc_pkg;

  // ==========================================================================
  // Command codes and register reset values
  localparam logic [7:0]  CMD_PEAK_LIMIT      = 8'h46;
  localparam logic [7:0]  CMD_PEAK_REACTION   = 8'h47;
  localparam logic [15:0] PEAK_LIMIT_RESET    = 16'h0019;
  localparam logic [7:0]  PEAK_REACTION_RESET = 8'h80;

  // ==========================================================================
  // Field layout of the two-byte limit word
  localparam int          LIM_EXP_MSB  = 15;
  localparam int          LIM_EXP_LSB  = 11;
  localparam int          LIM_MAN_MSB  = 10;
  localparam int          LIM_MAN_LSB  = 0;
  localparam logic [4:0]  LIM_EXP_OK   = 5'h00;
  localparam logic [10:0] LIM_MAN_MIN  = 11'h001;
  localparam logic [10:0] LIM_MAN_MAX  = 11'h01f;

  // ==========================================================================
  // Field layout of the reaction byte
  localparam int         RSP_MODE_MSB  = 7;
  localparam int         RSP_MODE_LSB  = 6;
  localparam int         RSP_RETRY_MSB = 5;
  localparam int         RSP_RETRY_LSB = 3;
  localparam int         RSP_DLY_MSB   = 2;
  localparam int         RSP_DLY_LSB   = 0;
  localparam logic [2:0] RETRY_LATCH   = 3'h0;
  localparam logic [2:0] RETRY_HICCUP  = 3'h7;

  typedef enum logic [1:0] {
    MODE_IGNORE   = 2'h0,
    MODE_UV_ONLY  = 2'h1,
    MODE_DELAYED  = 2'h2,
    MODE_SHUTDOWN = 2'h3
  } resp_mode_t;

  // ==========================================================================
  // Status bit positions
  localparam int STATUS_IOUT_OC_BIT   = 7;
  localparam int STATUS_WORD_IOUT_BIT = 14;
  localparam int STATUS_BYTE_IOUT_BIT = 4;

  // ==========================================================================
  // Timing: delay codes are multiples of the 160 us base window
  localparam int CLK_MHZ        = 100;
  localparam int DELAY_UNIT_US  = 160;
  localparam int HICCUP_MS      = 1000;
  localparam int DELAY_UNIT_CYC = DELAY_UNIT_US * CLK_MHZ;
  localparam int HICCUP_CYC     = HICCUP_MS * 1000 * CLK_MHZ;
  localparam int TIMER_W        = 32;

endpackage

//--- hdl/fault_timer.sv
module fault_timer #(
  parameter int W = 32
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic         i_start,
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_count,
  output logic              o_expired
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         exp_q;
  logic         exp_d;

  // ==========================================================================
  // Down counter, reloaded on start, stopped when not running
  always_comb begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (i_start) begin
      cnt_d = i_count;
    end else if (i_run && cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
      exp_d = (cnt_q == {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign o_expired = exp_q;

endmodule

//--- hdl/peak_oc_fault.sv
// Overview of operation
// [RULE1] Limit is a two-byte word: 5-bit unsigned exponent, 11-bit mantissa.
// [RULE2] Peak high-side current above the limit raises the peak over-current fault.
// [RULE3] Limit spans 1 to 31 A in 1 A steps, reset value 0019.
// [RULE4] Exponent is fixed; a write with any other exponent flags invalid data.
// [RULE5] Only codes 0001 to 001F accepted; anything else flags invalid data.
// [RULE6] STORE_USER_ALL copies limit and reaction to nonvolatile storage.
// [RULE7] Fault sets IOUT status bits, STATUS_IOUT bit 7 and pulls alert low.
// [RULE8] Fault bit stays set until the fault-clear command.
// [RULE9] Reaction register resets to 80, latch-off.
// [RULE10] Mode 00: keep running, current held at the limit.
// [RULE11] Mode 01: keep running unless output under-voltage is detected.
// [RULE12] Mode 10: limit for the delay, then apply retry if still limiting.
// [RULE13] Mode 11: shut down at once, then apply retry.
// [RULE14] Retry 000: stay off until faults are cleared.
// [RULE15] Retry 111: hiccup every 1 s until commanded off, power lost or other fault.
// [RULE16] Retry codes 001 to 110 refused with an invalid data fault.
// [RULE17] Delay bits 2:0 pick 160 us up to 10.08 ms windows.
// [RULE18] Delay timer counts clocks, restarts on limit start, expires inside window.
module peak_oc_fault
  import peak_oc_pkg::*;
#(
  parameter int DLY_UNIT_CYC = DELAY_UNIT_CYC,
  parameter int HICCUP_CYCS  = HICCUP_CYC,
  parameter int SENSE_W      = 11
) (
  input  wire logic               i_clk,
  input  wire logic               i_srst,
  input  wire logic               i_cmd_wr,
  input  wire logic               i_cmd_rd,
  input  wire logic [7:0]         i_cmd_code,
  input  wire logic [15:0]        i_cmd_wdata,
  input  wire logic               i_clear_faults,
  input  wire logic               i_store_user_all,
  input  wire logic [SENSE_W-1:0] i_hs_peak_current,
  input  wire logic               i_output_undervoltage_detect,
  input  wire logic               i_enable_pin,
  input  wire logic               i_operation_on,
  input  wire logic               i_input_power_good,
  input  wire logic               i_other_fault_off,
  output logic [15:0]             o_cmd_rdata,
  output logic                    o_host_alert_out_n,
  output logic [7:0]              o_status_iout,
  output logic [15:0]             o_status_word,
  output logic [7:0]              o_status_byte,
  output logic                    o_invalid_data,
  output logic                    o_output_on,
  output logic                    o_current_limit,
  output logic [10:0]             o_limit_amps,
  output logic                    o_nvm_store,
  output logic [15:0]             o_nvm_limit,
  output logic [7:0]              o_nvm_reaction
);

  typedef enum logic [2:0] {
    ST_RUN,
    ST_LIMIT,
    ST_LATCHED,
    ST_HICCUP
  } prot_state_t;

  // ==========================================================================
  // Decoding helpers
  function automatic logic limit_ok(input logic [15:0] w);
    limit_ok = (w[LIM_EXP_MSB:LIM_EXP_LSB] == LIM_EXP_OK) &&
               (w[LIM_MAN_MSB:LIM_MAN_LSB] >= LIM_MAN_MIN) &&
               (w[LIM_MAN_MSB:LIM_MAN_LSB] <= LIM_MAN_MAX);
  endfunction

  function automatic logic reaction_ok(input logic [7:0] b);
    reaction_ok = (b[RSP_RETRY_MSB:RSP_RETRY_LSB] == RETRY_LATCH) ||
                  (b[RSP_RETRY_MSB:RSP_RETRY_LSB] == RETRY_HICCUP);
  endfunction

  function automatic logic [6:0] delay_mult(input logic [2:0] code);
    case (code)
      3'h0:    delay_mult = 7'h01;
      3'h1:    delay_mult = 7'h02;
      3'h2:    delay_mult = 7'h04;
      3'h3:    delay_mult = 7'h08;
      3'h4:    delay_mult = 7'h10;
      3'h5:    delay_mult = 7'h20;
      3'h6:    delay_mult = 7'h3c;
      default: delay_mult = 7'h3f;
    endcase
  endfunction

  // ==========================================================================
  // Two-flop synchronisers for pin-level inputs
  localparam int NSYNC = 4;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;

  assign pin_raw = {i_other_fault_off, i_input_power_good, i_enable_pin, i_output_undervoltage_detect};

  generate
    for (genvar g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= pin_raw[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  logic uv_s;
  logic en_s;
  logic pg_s;
  logic other_s;
  assign uv_s    = sync2_q[0];
  assign en_s    = sync2_q[1];
  assign pg_s    = sync2_q[2];
  assign other_s = sync2_q[3];

  // ==========================================================================
  // Registers and sticky flags
  logic [15:0] limit_q;
  logic [15:0] limit_d;
  logic [7:0]  react_q;
  logic [7:0]  react_d;
  logic        oc_flag_q;
  logic        oc_flag_d;
  logic        cml_q;
  logic        cml_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic        store_q;
  logic        store_d;
  logic [15:0] nvm_lim_q;
  logic [15:0] nvm_lim_d;
  logic [7:0]  nvm_rsp_q;
  logic [7:0]  nvm_rsp_d;
  logic        over;
  logic        wr_lim;
  logic        wr_rsp;

  assign wr_lim = i_cmd_wr && (i_cmd_code == CMD_PEAK_LIMIT);
  assign wr_rsp = i_cmd_wr && (i_cmd_code == CMD_PEAK_REACTION);
  assign over   = i_hs_peak_current > SENSE_W'(limit_q[LIM_MAN_MSB:LIM_MAN_LSB]); // [RULE2]

  // Next values for the command registers, flags and storage copy
  always_comb begin
    limit_d   = limit_q;
    react_d   = react_q;
    cml_d     = cml_q;
    rdata_d   = rdata_q;
    store_d   = 1'b0;
    nvm_lim_d = nvm_lim_q;
    nvm_rsp_d = nvm_rsp_q;
    // Clear first, so a refused write in the same cycle still sets the flag
    if (i_clear_faults) begin
      cml_d = 1'b0;
    end
    if (wr_lim) begin
      if (limit_ok(i_cmd_wdata)) begin // [RULE1] [RULE3] [RULE4] [RULE5]
        limit_d = i_cmd_wdata;
      end else begin
        cml_d = 1'b1; // [RULE4] [RULE5]
      end
    end
    if (wr_rsp) begin
      if (reaction_ok(i_cmd_wdata[7:0])) begin
        react_d = i_cmd_wdata[7:0];
      end else begin
        cml_d = 1'b1; // [RULE16]
      end
    end
    if (i_cmd_rd) begin
      unique case (i_cmd_code)
        CMD_PEAK_LIMIT:    rdata_d = limit_q;
        CMD_PEAK_REACTION: rdata_d = {8'h00, react_q};
        default:           rdata_d = 16'h0000;
      endcase
    end
    if (i_store_user_all) begin
      store_d   = 1'b1; // [RULE6]
      nvm_lim_d = limit_q;
      nvm_rsp_d = react_q;
    end
    oc_flag_d = over || (oc_flag_q && !i_clear_faults); // [RULE8]
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      limit_q   <= PEAK_LIMIT_RESET; // [RULE3]
      react_q   <= PEAK_REACTION_RESET; // [RULE9]
      oc_flag_q <= 1'b0;
      cml_q     <= 1'b0;
      rdata_q   <= 16'h0000;
      store_q   <= 1'b0;
      nvm_lim_q <= PEAK_LIMIT_RESET;
      nvm_rsp_q <= PEAK_REACTION_RESET;
    end else begin
      limit_q   <= limit_d;
      react_q   <= react_d;
      oc_flag_q <= oc_flag_d;
      cml_q     <= cml_d;
      rdata_q   <= rdata_d;
      store_q   <= store_d;
      nvm_lim_q <= nvm_lim_d;
      nvm_rsp_q <= nvm_rsp_d;
    end
  end

  // ==========================================================================
  // Protection state machine
  prot_state_t st_q;
  prot_state_t st_d;
  resp_mode_t  mode;
  logic [2:0]  retry;
  logic        cmd_off;
  logic        dly_start;
  logic        dly_exp;
  logic        hic_start;
  logic        hic_exp;
  logic        on_q;
  logic        on_d;
  logic        lim_q;
  logic        lim_d;
  logic [TIMER_W-1:0] dly_count;

  assign mode    = resp_mode_t'(react_q[RSP_MODE_MSB:RSP_MODE_LSB]);
  assign retry   = react_q[RSP_RETRY_MSB:RSP_RETRY_LSB];
  assign cmd_off = !en_s || !i_operation_on || !pg_s || other_s;
  assign dly_count = TIMER_W'(DLY_UNIT_CYC) * TIMER_W'(delay_mult(react_q[RSP_DLY_MSB:RSP_DLY_LSB])); // [RULE17]

  // Next state, timer starts and output controls
  always_comb begin
    st_d      = st_q;
    dly_start = 1'b0;
    hic_start = 1'b0;
    unique case (st_q)
      ST_RUN: begin
        if (over) begin
          unique case (mode)
            MODE_IGNORE:   st_d = ST_RUN; // [RULE10]
            MODE_UV_ONLY:  st_d = uv_s ? ST_LATCHED : ST_RUN; // [RULE11]
            MODE_DELAYED: begin
              st_d      = ST_LIMIT; // [RULE12]
              dly_start = 1'b1; // [RULE18]
            end
            MODE_SHUTDOWN: st_d = ST_LATCHED; // [RULE13]
          endcase
        end
      end
      ST_LIMIT: begin
        if (!over) begin
          st_d = ST_RUN;
        end else if (dly_exp) begin
          st_d = ST_LATCHED; // [RULE12]
        end
      end
      ST_LATCHED: begin
        if (retry == RETRY_HICCUP && !cmd_off) begin
          st_d      = ST_HICCUP; // [RULE15]
          hic_start = 1'b1;
        end else if (i_clear_faults && !over) begin
          st_d = ST_RUN; // [RULE14]
        end
      end
      ST_HICCUP: begin
        if (cmd_off) begin
          st_d = ST_LATCHED; // [RULE15]
        end else if (hic_exp) begin
          st_d = ST_RUN;
        end
      end
      default: st_d = ST_LATCHED;
    endcase
    // Hiccup retries pause while the part is commanded off and resume once it is released
    if (st_q == ST_LATCHED && cmd_off && retry == RETRY_HICCUP) begin
      st_d = (i_clear_faults && !over) ? ST_RUN : ST_LATCHED;
    end
    on_d  = (st_d == ST_RUN) || (st_d == ST_LIMIT);
    lim_d = over && on_d && (mode == MODE_IGNORE || mode == MODE_UV_ONLY || mode == MODE_DELAYED); // [RULE10]
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q  <= ST_RUN;
      on_q  <= 1'b1;
      lim_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      on_q  <= on_d;
      lim_q <= lim_d;
    end
  end

  // ==========================================================================
  // Current-limit delay and hiccup timers
  fault_timer #(
    .W (TIMER_W)
  ) u_delay (
    .i_clk     (i_clk),
    .i_srst    (i_srst),
    .i_start   (dly_start),
    .i_run     (st_q == ST_LIMIT),
    .i_count   (dly_count),
    .o_expired (dly_exp)
  );

  fault_timer #(
    .W (TIMER_W)
  ) u_hiccup (
    .i_clk     (i_clk),
    .i_srst    (i_srst),
    .i_start   (hic_start),
    .i_run     (st_q == ST_HICCUP),
    .i_count   (TIMER_W'(HICCUP_CYCS)),
    .o_expired (hic_exp)
  );

  // ==========================================================================
  // Outputs
  always_comb begin
    o_status_iout                     = 8'h00;
    o_status_word                     = 16'h0000;
    o_status_byte                     = 8'h00;
    o_status_iout[STATUS_IOUT_OC_BIT] = oc_flag_q; // [RULE7]
    o_status_word[STATUS_WORD_IOUT_BIT] = oc_flag_q;
    o_status_byte[STATUS_BYTE_IOUT_BIT] = oc_flag_q;
  end

  assign o_host_alert_out_n = !(oc_flag_q || cml_q); // [RULE7]
  assign o_cmd_rdata        = rdata_q;
  assign o_invalid_data     = cml_q;
  assign o_output_on        = on_q;
  assign o_current_limit    = lim_q;
  assign o_limit_amps       = limit_q[LIM_MAN_MSB:LIM_MAN_LSB];
  assign o_nvm_store        = store_q;
  assign o_nvm_limit        = nvm_lim_q;
  assign o_nvm_reaction     = nvm_rsp_q;

endmodule

//--- test/peak_oc_properties.sv
module peak_oc_properties
  import peak_oc_pkg::*;
#(
  parameter int SENSE_W = 11
) (
  input wire logic               i_clk,
  input wire logic               i_srst,
  input wire logic               i_cmd_wr,
  input wire logic [7:0]         i_cmd_code,
  input wire logic [15:0]        i_cmd_wdata,
  input wire logic               i_clear_faults,
  input wire logic               i_store_user_all,
  input wire logic [SENSE_W-1:0] i_hs_peak_current,
  input wire logic               o_host_alert_out_n,
  input wire logic [7:0]         o_status_iout,
  input wire logic [15:0]        o_status_word,
  input wire logic [7:0]         o_status_byte,
  input wire logic               o_invalid_data,
  input wire logic [10:0]        o_limit_amps,
  input wire logic               o_nvm_store
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // ====
  // Fault flag and status
  AST_OC_SET: assert property (i_hs_peak_current > o_limit_amps |=> o_status_iout[7])
    else $error("oc flag missed");
  AST_STICKY: assert property (o_status_iout[7] && !i_clear_faults |=> o_status_iout[7])
    else $error("oc flag dropped");
  AST_STATUS: assert property (o_status_iout[7] |-> o_status_word[14] && o_status_byte[4])
    else $error("status summary bits");
  AST_ALERT: assert property (o_host_alert_out_n == !(o_status_iout[7] || o_invalid_data))
    else $error("alert level");

  // ====
  // Command writes and store
  AST_BAD_EXP: assert property (i_cmd_wr && i_cmd_code == 8'h46 && i_cmd_wdata[15:11] != 5'h00
    |=> o_invalid_data && $stable(o_limit_amps)) else $error("bad exponent taken");
  AST_BAD_RETRY: assert property (i_cmd_wr && i_cmd_code == 8'h47
    && i_cmd_wdata[5:3] inside {[3'h1:3'h6]} |=> o_invalid_data) else $error("bad retry taken");
  AST_GOOD_LIM: assert property (i_cmd_wr && i_cmd_code == 8'h46
    && i_cmd_wdata inside {[16'h0001:16'h001f]} |=> {5'h00, o_limit_amps} == $past(i_cmd_wdata))
    else $error("limit not stored");
  AST_STORE: assert property (i_store_user_all |=> o_nvm_store)
    else $error("store pulse missing");
  AST_RST_LIM: assert property ($fell(i_srst) |-> o_limit_amps == 11'h019)
    else $error("limit reset value");
endmodule

bind peak_oc_fault peak_oc_properties #(.SENSE_W(SENSE_W)) u_props (.i_clk, .i_srst, .i_cmd_wr, .i_cmd_code,
  .i_cmd_wdata, .i_clear_faults, .i_store_user_all, .i_hs_peak_current, .o_host_alert_out_n, .o_status_iout,
  .o_status_word, .o_status_byte, .o_invalid_data, .o_limit_amps, .o_nvm_store);

//--- test/pmbus_host_model.sv
module pmbus_host_model (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_cmd_rdata,
  output logic             o_cmd_wr,
  output logic             o_cmd_rd,
  output logic [7:0]       o_cmd_code,
  output logic [15:0]      o_cmd_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle command port
  initial begin
    o_cmd_wr = 1'b0;
    o_cmd_rd = 1'b0;
    o_cmd_code = 8'h00;
    o_cmd_wdata = 16'h0000;
  end

  // One write; the word goes whole, then the data lines stop showing it
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge i_clk);
    o_cmd_wr <= 1'b1;
    o_cmd_code <= c;
    o_cmd_wdata <= d;
    @(posedge i_clk);
    o_cmd_wr <= 1'b0;
    o_cmd_wdata <= ~d;
  endtask

  // One read; data is taken once the registered answer has landed
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    @(posedge i_clk);
    o_cmd_rd <= 1'b1;
    o_cmd_code <= c;
    @(posedge i_clk);
    o_cmd_rd <= 1'b0;
    #1;
    d = i_cmd_rdata;
  endtask
endmodule

//--- test/testbench.sv
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_errors++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import peak_oc_pkg::*;
  localparam int DU = 10;
  localparam int HC = 50;
  logic        i_clk, i_srst, clr, store, uv, en, cmd_wr, cmd_rd, alert_n, inval, out_on, lim_on, nvm_st;
  logic        op_on, pg, oth;
  logic [10:0] cur, amps;
  logic [7:0]  cmd_code, s_iout, s_byte, nvm_rsp;
  logic [15:0] cmd_wdata, rdata, rd, s_word, nvm_lim;
  logic [15:0] tl [6] = '{16'h0001, 16'h001f, 16'h0000, 16'h0020, 16'h0819, 16'hf805};
  int          mult [8] = '{1, 2, 4, 8, 16, 32, 60, 63};
  int          n_errors = 0;
  int          cmp_count = 0;
  int          lim = 25;
  int          rsp = 'h80;
  int          k;
  int          n_on;

  // ====
  // Design, host model and clock
  peak_oc_fault #(.DLY_UNIT_CYC(DU), .HICCUP_CYCS(HC)) dut (.i_clk, .i_srst, .i_cmd_wr(cmd_wr),
    .i_cmd_rd(cmd_rd), .i_cmd_code(cmd_code), .i_cmd_wdata(cmd_wdata), .i_clear_faults(clr),
    .i_store_user_all(store), .i_hs_peak_current(cur), .i_output_undervoltage_detect(uv), .i_enable_pin(en),
    .i_operation_on(op_on), .i_input_power_good(pg), .i_other_fault_off(oth), .o_cmd_rdata(rdata),
    .o_host_alert_out_n(alert_n), .o_status_iout(s_iout), .o_status_word(s_word), .o_status_byte(s_byte),
    .o_invalid_data(inval), .o_output_on(out_on), .o_current_limit(lim_on), .o_limit_amps(amps),
    .o_nvm_store(nvm_st), .o_nvm_limit(nvm_lim), .o_nvm_reaction(nvm_rsp));
  pmbus_host_model host (.i_clk, .i_cmd_rdata(rdata), .o_cmd_wr(cmd_wr), .o_cmd_rd(cmd_rd),
    .o_cmd_code(cmd_code), .o_cmd_wdata(cmd_wdata));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ====
  // Helpers
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic pulse_clr();
    @(posedge i_clk);
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
    #1;
  endtask
  task automatic drive(input logic [10:0] c);
    @(posedge i_clk);
    cur <= c;
    step(1);
  endtask
  task automatic wait_on(input int n, input logic v);
    for (k = 0; k < n && out_on !== v; k++) step(1);
    `CHK("output_on", v, out_on)
    if (out_on !== v) complete_run();
  endtask
  // Clear while stop causes still hold, then release them
  task automatic restore();
    @(posedge i_clk);
    uv <= 1'b0;
    cur <= 11'h000;
    step(1);
    pulse_clr();
    @(posedge i_clk);
    en <= 1'b1;
    op_on <= 1'b1;
    pg <= 1'b1;
    oth <= 1'b0;
    step(3);
    wait_on(4, 1'b1);
  endtask
  // Write through the host, update the model, read back, clear
  task automatic put(input logic [7:0] c, input logic [15:0] d);
    bit ok;
    ok = (c == 8'h46) ? (d >= 1 && d <= 31) : !(d[5:3] inside {[1:6]});
    host.wr(c, d);
    #1;
    if (ok && c == 8'h46) lim = d;
    if (ok && c == 8'h47) rsp = d[7:0];
    `CHK("invalid", !ok, inval)
    `CHK("amps", lim, amps)
    host.rd(c, rd);
    `CHK("readback", (c == 8'h46) ? lim : rsp, rd)
    pulse_clr();
  endtask
  task automatic endt(input string nm);
    $display("test %s ended, errors %0d", nm, n_errors);
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    #600000;
    n_errors++;
    complete_run();
  end

  // ====
  // Main sequence
  initial begin
    i_srst = 1'b1;
    clr = 1'b0;
    store = 1'b0;
    uv = 1'b0;
    en = 1'b1;
    op_on = 1'b1;
    pg = 1'b1;
    oth = 1'b0;
    cur = 11'h000;
    void'($urandom(32'he7e9));
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    step(1);
    host.rd(8'h46, rd);
    `CHK("limit_rst", 16'h0019, rd)
    host.rd(8'h47, rd);
    `CHK("reaction_rst", 16'h0080, rd)
    host.rd(8'h48, rd);
    `CHK("unmapped", 16'h0000, rd)
    endt("reset");
    foreach (tl[i]) put(8'h46, tl[i]);
    for (int i = 0; i < 10; i++) put(8'h46, (i % 2) ? 16'(1 + $urandom % 31) : 16'($urandom));
    for (int r = 0; r < 8; r++) put(8'h47, 16'((r << 3) | 'hc0));
    endt("writes");
    put(8'h46, 16'h0005);
    put(8'h47, 16'h00c0);
    drive(11'd6);
    `CHK("oc_bit", 1'b1, s_iout[7])
    `CHK("word", 1'b1, s_word[14])
    `CHK("byte", 1'b1, s_byte[4])
    `CHK("alert_n", 1'b0, alert_n)
    `CHK("shut", 1'b0, out_on)
    drive(11'd5);
    step(8);
    `CHK("sticky", 1'b1, s_iout[7])
    `CHK("latched", 1'b0, out_on)
    restore();
    `CHK("cleared", 1'b0, s_iout[7])
    endt("shutdown");
    put(8'h47, 16'h0000);
    drive(11'd9);
    `CHK("limiting", 1'b1, lim_on)
    step(30);
    `CHK("ignore_on", 1'b1, out_on)
    restore();
    put(8'h47, 16'h0040);
    drive(11'd9);
    step(10);
    `CHK("no_uv_on", 1'b1, out_on)
    @(posedge i_clk);
    uv <= 1'b1;
    wait_on(6, 1'b0);
    restore();
    endt("modes");
    foreach (mult[d]) begin
      put(8'h47, 16'(8'h80 | d));
      drive(11'd9);
      step(DU * mult[d] - 3);
      `CHK("pre_expiry", 1'b1, out_on)
      wait_on(8, 1'b0);
      restore();
    end
    put(8'h47, 16'h0082);
    drive(11'd9);
    step(30);
    drive(11'd0);
    drive(11'd9);
    step(30);
    `CHK("restarted", 1'b1, out_on)
    restore();
    endt("delay");
    put(8'h47, 16'h00f8);
    drive(11'd9);
    `CHK("hiccup_off", 1'b0, out_on)
    drive(11'd0);
    step(HC - 5);
    `CHK("hiccup_wait", 1'b0, out_on)
    wait_on(15, 1'b1);
    // Each stop cause in turn: enable, operation, power, other fault
    for (int c = 0; c < 4; c++) begin
      drive(11'd9);
      @(posedge i_clk);
      en <= (c != 0);
      op_on <= (c != 1);
      pg <= (c != 2);
      oth <= (c == 3);
      n_on = 0;
      for (k = 0; k < HC + 20; k++) begin
        step(1);
        if (out_on !== 1'b0) n_on++;
      end
      `CHK("cmd_off", 0, n_on)
      restore();
    end
    endt("hiccup");
    put(8'h46, 16'h0007);
    @(posedge i_clk);
    store <= 1'b1;
    @(posedge i_clk);
    store <= 1'b0;
    #1;
    `CHK("store", 1'b1, nvm_st)
    `CHK("nvm_limit", lim, nvm_lim)
    `CHK("nvm_reaction", rsp, nvm_rsp)
    endt("store");
    complete_run();
  end
endmodule
